// file: src/block_ram_fifo_controller.sv
// synchronous block ram fifo controller with axi4-lite control port
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
// Behaviour
// R01: queue works only in 40K configuration
// R02: second port pushes, first port pops
// R03: synchronous mode uses one shared clock
// R04: push and pop widths must match
// R05: internal pointers replace external addresses
// R06: thresholds static or from offset inputs
// R07: active-low queue reset synchronised internally
// R08: full when every entry occupied
// R09: empty when no entries stored
// R10: almost-full and almost-empty early warnings
// R11: read and write pointers exposed, 16 bits
// R12: read error on pop while empty
// R13: write error on push while full, word lost
// R14: 40-bit form uses second port buses
// R15: 80-bit form concatenates upper and lower
// R16: push needs enable and write-enable; pop enable
// R17: pointers advance on shared clock edge
// R18: flags combinational from pointers, not sticky
// R19: async pointers registered in own domains; no async mode here, both pointers are registered on clk_in
// R20: async pointers gray-coded, two-stage synchronised; no async mode here, both pointers are binary counters on clk_in
// R21: pop-side flags exact in pop domain
// R22: push-side flags exact in push domain
// R23: bit written only with enables and mask
// R24: refused push or pop keeps pointer
// R25: almost flags at or below offset
module block_ram_fifo_controller #(
   parameter int unsigned ADDR_W = ram_fifo_pkg::DEPTH_LOG2
) (
   // clock and reset
   input  wire logic                                clk_in,
   input  wire logic                                rst_n_in,
   input  wire logic                                fifo_rst_n_in,
   // push side
   input  wire logic                                push_en_in,
   input  wire logic                                push_we_in,
   input  wire logic [ram_fifo_pkg::HALF_W-1:0]     push_data_upper_in,
   input  wire logic [ram_fifo_pkg::HALF_W-1:0]     push_data_lower_in,
   input  wire logic [ram_fifo_pkg::HALF_W-1:0]     push_mask_upper_in,
   input  wire logic [ram_fifo_pkg::HALF_W-1:0]     push_mask_lower_in,
   // pop side
   input  wire logic                                pop_en_in,
   output logic      [ram_fifo_pkg::HALF_W-1:0]     pop_data_upper_out,
   output logic      [ram_fifo_pkg::HALF_W-1:0]     pop_data_lower_out,
   // dynamic thresholds
   input  wire logic [ram_fifo_pkg::OFFSET_W-1:0]   almost_full_offset_in,
   input  wire logic [ram_fifo_pkg::OFFSET_W-1:0]   almost_empty_offset_in,
   // status
   output logic                                     full_out,
   output logic                                     empty_out,
   output logic                                     almost_full_out,
   output logic                                     almost_empty_out,
   output logic                                     read_error_out,
   output logic                                     write_error_out,
   output logic      [ram_fifo_pkg::PTR_OUT_W-1:0]  read_pointer_out,
   output logic      [ram_fifo_pkg::PTR_OUT_W-1:0]  write_pointer_out,
   // axi4-lite write address
   input  wire logic [31:0]                         s_axi_awaddr,
   input  wire logic                                s_axi_awvalid,
   output logic                                     s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]                         s_axi_wdata,
   input  wire logic [3:0]                          s_axi_wstrb,
   input  wire logic                                s_axi_wvalid,
   output logic                                     s_axi_wready,
   // axi4-lite write response
   output logic      [1:0]                          s_axi_bresp,
   output logic                                     s_axi_bvalid,
   input  wire logic                                s_axi_bready,
   // axi4-lite read address
   input  wire logic [31:0]                         s_axi_araddr,
   input  wire logic                                s_axi_arvalid,
   output logic                                     s_axi_arready,
   // axi4-lite read data
   output logic      [31:0]                         s_axi_rdata,
   output logic      [1:0]                          s_axi_rresp,
   output logic                                     s_axi_rvalid,
   input  wire logic                                s_axi_rready
);
   import ram_fifo_pkg::*;

   localparam int unsigned DEPTH = 1 << ADDR_W;

   // queue state
   logic [FULL_W-1:0]   mem_q [DEPTH];
   logic [ADDR_W:0]     wr_ptr_q;
   logic [ADDR_W:0]     rd_ptr_q;
   logic [ADDR_W:0]     fill;
   logic [ADDR_W:0]     free;

   // configuration
   logic [2:0]          ctrl_q;
   logic [OFFSET_W-1:0] af_cfg_q;
   logic [OFFSET_W-1:0] ae_cfg_q;
   logic [OFFSET_W-1:0] af_off;
   logic [OFFSET_W-1:0] ae_off;
   logic [SYNC_STAGES-1:0] frst_sync_q;

   // datapath
   logic                fifo_run;
   logic                wide;
   logic                push_req;
   logic                pop_req;
   logic                do_push;
   logic                do_pop;
   logic [FULL_W-1:0]   push_data;
   logic [FULL_W-1:0]   push_mask;
   logic [FULL_W-1:0]   pop_data_q;

   // bus side
   logic                aw_held_q;
   logic                w_held_q;
   logic [31:0]         aw_addr_q;
   logic [31:0]         w_data_q;
   logic [3:0]          w_strb_q;
   logic                wr_fire;

   // bus decode
   logic                wr_hit_ctrl;
   logic                wr_hit_af;
   logic                wr_hit_ae;
   logic                wr_mapped;
   logic [31:0]         status_word;
   logic [31:0]         rd_word;
   logic                rd_mapped;

   // fifo reset synchroniser, release after two clocks
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !fifo_rst_n_in) begin
         frst_sync_q <= '0; // R07
      end else begin
         frst_sync_q <= {frst_sync_q[SYNC_STAGES-2:0], 1'b1}; // R07
      end
   end

   assign fifo_run = frst_sync_q[SYNC_STAGES-1] && ctrl_q[CTRL_40K_BIT]; // R01
   assign wide     = ctrl_q[CTRL_WIDE_BIT];

   // data forming
   always_comb begin
      if (wide) begin
         push_data = {push_data_upper_in, push_data_lower_in}; // R15
         push_mask = {push_mask_upper_in, push_mask_lower_in}; // R15
      end else begin
         push_data = {{HALF_W{1'b0}}, push_data_upper_in}; // R14
         push_mask = {{HALF_W{1'b0}}, push_mask_upper_in}; // R14
      end
   end

   // flags from pointers
   assign fill     = wr_ptr_q - rd_ptr_q;
   assign free     = (ADDR_W+1)'(DEPTH) - fill;
   assign af_off   = ctrl_q[CTRL_DYN_BIT] ? almost_full_offset_in : af_cfg_q; // R06
   assign ae_off   = ctrl_q[CTRL_DYN_BIT] ? almost_empty_offset_in : ae_cfg_q; // R06

   always_comb begin
      full_out         = fill[ADDR_W]; // R08 R18
      empty_out        = (fill == '0); // R09 R18
      almost_full_out  = (OFFSET_W'(free) <= af_off); // R10 R25
      almost_empty_out = (OFFSET_W'(fill) <= ae_off); // R10 R25
      read_error_out   = fifo_run && pop_req && empty_out; // R12 R18 R21
      write_error_out  = fifo_run && push_req && full_out; // R13 R18 R22
   end

   always_comb begin
      push_req = push_en_in && push_we_in; // R16 R02
      pop_req  = pop_en_in; // R16 R02
      do_push  = fifo_run && push_req && !full_out; // R24 R22
      do_pop   = fifo_run && pop_req && !empty_out; // R24 R21
   end

   // pointers on the shared clock
   always_ff @(posedge clk_in) begin
      if (!frst_sync_q[SYNC_STAGES-1]) begin
         wr_ptr_q <= '0;
      end else if (do_push) begin
         wr_ptr_q <= wr_ptr_q + 1'b1; // R03 R17 R19 R24
      end
   end

   always_ff @(posedge clk_in) begin
      if (!frst_sync_q[SYNC_STAGES-1]) begin
         rd_ptr_q <= '0;
      end else if (do_pop) begin
         rd_ptr_q <= rd_ptr_q + 1'b1; // R03 R17 R19 R24
      end
   end

   // storage, per-bit masked writes at internal address
   genvar gi;
   generate
      for (gi = 0; gi < FULL_W; gi++) begin : g_bit
         always_ff @(posedge clk_in) begin
            if (do_push && push_mask[gi]) begin
               mem_q[wr_ptr_q[ADDR_W-1:0]][gi] <= push_data[gi]; // R05 R23
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pop_data_q <= '0;
      end else if (do_pop) begin
         pop_data_q <= mem_q[rd_ptr_q[ADDR_W-1:0]]; // R05 R17
      end
   end

   always_comb begin
      if (wide) begin
         pop_data_upper_out = pop_data_q[FULL_W-1:HALF_W]; // R15
         pop_data_lower_out = pop_data_q[HALF_W-1:0]; // R15
      end else begin
         pop_data_upper_out = pop_data_q[HALF_W-1:0]; // R14
         pop_data_lower_out = '0; // R14
      end
   end

   assign read_pointer_out  = PTR_OUT_W'(rd_ptr_q[ADDR_W-1:0]); // R11
   assign write_pointer_out = PTR_OUT_W'(wr_ptr_q[ADDR_W-1:0]); // R11

   // axi4-lite write path: address and data in either order
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
   assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;

   always_comb begin
      wr_hit_ctrl = (aw_addr_q == REG_CTRL);
      wr_hit_af   = (aw_addr_q == REG_AF_OFFSET);
      wr_hit_ae   = (aw_addr_q == REG_AE_OFFSET);
      wr_mapped   = wr_hit_ctrl || wr_hit_af || wr_hit_ae;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_q   <= CTRL_RST;
         af_cfg_q <= AF_OFFSET_RST;
         ae_cfg_q <= AE_OFFSET_RST;
      end else if (wr_fire) begin
         if (wr_hit_ctrl && w_strb_q[0]) begin
            ctrl_q <= w_data_q[2:0];
         end
         if (wr_hit_af) begin
            if (w_strb_q[0]) begin
               af_cfg_q[7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
               af_cfg_q[12:8] <= w_data_q[12:8];
            end
         end
         if (wr_hit_ae) begin
            if (w_strb_q[0]) begin
               ae_cfg_q[7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
               ae_cfg_q[12:8] <= w_data_q[12:8];
            end
         end
      end
   end

   // axi4-lite read path
   assign s_axi_arready = !s_axi_rvalid;

   assign status_word = {26'h0, write_error_out, read_error_out,
                         almost_empty_out, almost_full_out,
                         empty_out, full_out};

   always_comb begin
      rd_word   = '0;
      rd_mapped = 1'b1;
      case (s_axi_araddr)
         REG_CTRL:      rd_word = {29'h0, ctrl_q};
         REG_AF_OFFSET: rd_word = {19'h0, af_cfg_q};
         REG_AE_OFFSET: rd_word = {19'h0, ae_cfg_q};
         REG_STATUS:    rd_word = status_word;
         REG_POINTERS:  rd_word = {write_pointer_out, read_pointer_out};
         default: begin
            rd_word   = '0;
            rd_mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : block_ram_fifo_controller

// file: src/ram_fifo_pkg.sv
// constants for the block ram fifo controller
package ram_fifo_pkg;
   localparam int unsigned HALF_W        = 40;
   localparam int unsigned FULL_W        = 80;
   localparam int unsigned PTR_OUT_W     = 16;
   localparam int unsigned OFFSET_W      = 13;
   localparam int unsigned DEPTH_LOG2    = 9;
   localparam int unsigned SYNC_STAGES   = 2;
   localparam logic [12:0] AF_OFFSET_RST = 13'h0004;
   localparam logic [12:0] AE_OFFSET_RST = 13'h0004;
   localparam logic [31:0] REG_CTRL      = 32'h0000_0000;
   localparam logic [31:0] REG_AF_OFFSET = 32'h0000_0004;
   localparam logic [31:0] REG_AE_OFFSET = 32'h0000_0008;
   localparam logic [31:0] REG_STATUS    = 32'h0000_000C;
   localparam logic [31:0] REG_POINTERS  = 32'h0000_0010;
   localparam int unsigned CTRL_WIDE_BIT = 0;
   localparam int unsigned CTRL_DYN_BIT  = 1;
   localparam int unsigned CTRL_40K_BIT  = 2;
   localparam logic [2:0]  CTRL_RST      = 3'h4;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : ram_fifo_pkg

// file: tb/block_ram_fifo_controller_tb_top.sv
// testbench for the block ram fifo controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", n, e, g); end end
module block_ram_fifo_controller_tb_top;
   import ram_fifo_pkg::*;
   logic        clk_in = 1'b0, rst_n_in = 1'b0, fifo_rst_n_in = 1'b0;
   logic        push_en_in, push_we_in, pop_en_in;
   logic [39:0] push_data_upper_in, push_data_lower_in, push_mask_upper_in, push_mask_lower_in;
   logic [39:0] pop_data_upper_out, pop_data_lower_out;
   logic [12:0] almost_full_offset_in = 13'h0004, almost_empty_offset_in = 13'h0004;
   logic        full_out, empty_out, almost_full_out, almost_empty_out;
   logic        read_error_out, write_error_out;
   logic [15:0] read_pointer_out, write_pointer_out;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [79:0] d;
   int          errors = 0;
   int          samples_checked = 0;
   int          i;
   always #4 clk_in = ~clk_in;
   block_ram_fifo_controller #(.ADDR_W(4)) dut (.*);
   fabric_user u (.clk_in, .push_en_out(push_en_in), .push_we_out(push_we_in),
      .pop_en_out(pop_en_in), .push_data_out({push_data_upper_in, push_data_lower_in}),
      .push_mask_out({push_mask_upper_in, push_mask_lower_in}));
   function automatic logic [79:0] w(input int k);
      return {40'hAAAAAAAA00 | 40'(k), 40'h5555555500 | 40'(k)};
   endfunction : w
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK("bresp", r, s_axi_bresp)
      @(posedge clk_in);
   endtask : axi_wr
   task automatic axi_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK("rdata", e, s_axi_rdata)
      `CHK("rresp", r, s_axi_rresp)
      @(posedge clk_in);
   endtask : axi_rd
   task automatic push_one(input logic [79:0] v);
      u.step(1'b1, 1'b0, v);
      @(posedge clk_in);
      u.step(1'b0, 1'b0, '0);
      @(posedge clk_in);
   endtask : push_one
   task automatic pop_chk(input logic [79:0] e);
      u.step(1'b0, 1'b1, '0);
      @(posedge clk_in);
      u.step(1'b0, 1'b0, '0);
      @(negedge clk_in);
      `CHK("pop data", e, {pop_data_upper_out, pop_data_lower_out})
      @(posedge clk_in);
   endtask : pop_chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   initial begin
      #20000;
      errors++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk_in);
      rst_n_in      <= 1'b1;
      fifo_rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      axi_rd(REG_CTRL, {29'h0, CTRL_RST}, RESP_OKAY);
      axi_rd(REG_AF_OFFSET, {19'h0, AF_OFFSET_RST}, RESP_OKAY);
      axi_rd(REG_AE_OFFSET, {19'h0, AE_OFFSET_RST}, RESP_OKAY);
      axi_rd(REG_STATUS, 32'h0000_000A, RESP_OKAY);
      axi_rd(32'h0000_0020, 32'h0, RESP_SLVERR);
      axi_wr(32'h0000_0020, 32'h0, RESP_SLVERR);
      $display("test registers done");
      axi_wr(REG_CTRL, 32'h0000_0005, RESP_OKAY);
      push_one(w(0));
      `CHK("write ptr", 16'h0001, write_pointer_out)
      axi_rd(REG_POINTERS, 32'h0001_0000, RESP_OKAY);
      `CHK("empty", 1'b0, empty_out)
      for (i = 1; i < 16; i++) begin
         u.step(1'b1, 1'b0, w(i));
         @(posedge clk_in);
      end
      u.step(1'b1, 1'b0, w(99));
      @(negedge clk_in);
      `CHK("full", 1'b1, full_out)
      `CHK("write error", 1'b1, write_error_out)
      @(posedge clk_in);
      u.step(1'b0, 1'b0, '0);
      @(posedge clk_in);
      for (i = 0; i < 16; i++) begin
         pop_chk(w(i));
         `CHK("almost empty", 1'((15 - i) <= 4), almost_empty_out)
         `CHK("almost full", 1'((i + 1) <= 4), almost_full_out)
      end
      `CHK("read ptr", 16'h0000, read_pointer_out)
      u.step(1'b0, 1'b1, '0);
      @(negedge clk_in);
      `CHK("read error", 1'b1, read_error_out)
      @(posedge clk_in);
      u.step(1'b0, 1'b0, '0);
      @(negedge clk_in);
      `CHK("read error", 1'b0, read_error_out)
      @(posedge clk_in);
      $display("test fill and drain done");
      almost_empty_offset_in <= 13'h0000;
      axi_wr(REG_CTRL, 32'h0000_0007, RESP_OKAY);
      `CHK("almost empty", 1'b1, almost_empty_out)
      push_one(w(20));
      `CHK("almost empty", 1'b0, almost_empty_out)
      pop_chk(w(20));
      $display("test thresholds done");
      axi_wr(REG_CTRL, 32'h0000_0004, RESP_OKAY);
      d = w(21);
      push_one(d);
      pop_chk({d[79:40], 40'h0});
      push_one(w(23));
      fifo_rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      fifo_rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      `CHK("empty", 1'b1, empty_out)
      `CHK("write ptr", 16'h0000, write_pointer_out)
      axi_wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
      push_one(w(22));
      `CHK("empty", 1'b1, empty_out)
      $display("test forms done");
      complete_run();
   end
endmodule : block_ram_fifo_controller_tb_top

// file: tb/fabric_user.sv
// fabric user logic model on the push and pop ports
`timescale 1ns/1ps
module fabric_user (
   // clock
   input  wire logic                              clk_in,
   // push and pop requests
   output logic                                   push_en_out,
   output logic                                   push_we_out,
   output logic                                   pop_en_out,
   output logic [ram_fifo_pkg::FULL_W-1:0]        push_data_out,
   output logic [ram_fifo_pkg::FULL_W-1:0]        push_mask_out
);
   import ram_fifo_pkg::*;
   initial begin
      push_en_out   = 1'b0;
      push_we_out   = 1'b0;
      pop_en_out    = 1'b0;
      push_data_out = '0;
      push_mask_out = '1;
   end
   // called right after a rising edge; idle data is inverted, never left stale
   task automatic step(input logic push, input logic pop, input logic [FULL_W-1:0] d);
      push_en_out   <= push;
      push_we_out   <= push;
      pop_en_out    <= pop;
      push_data_out <= push ? d : ~push_data_out;
      push_mask_out <= '1;
   endtask : step
endmodule : fabric_user

// file: tb/ram_fifo_chk.sv
// port assertions for the block ram fifo controller
`timescale 1ns/1ps
module ram_fifo_chk (
   // clock and resets
   input wire logic                                clk_in,
   input wire logic                                rst_n_in,
   input wire logic                                fifo_rst_n_in,
   // queue ports
   input wire logic                                push_en_in,
   input wire logic                                push_we_in,
   input wire logic                                pop_en_in,
   input wire logic                                full_out,
   input wire logic                                empty_out,
   input wire logic                                read_error_out,
   input wire logic                                write_error_out,
   input wire logic [ram_fifo_pkg::PTR_OUT_W-1:0]  read_pointer_out,
   input wire logic [ram_fifo_pkg::PTR_OUT_W-1:0]  write_pointer_out
);
   import ram_fifo_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in || !fifo_rst_n_in);
   a_full_vs_empty: assert property (!(full_out && empty_out))
      else $error("full and empty together");
   a_wr_err_cause: assert property (write_error_out |-> full_out && push_en_in && push_we_in)
      else $error("write error without push on full");
   a_rd_err_cause: assert property (read_error_out |-> empty_out && pop_en_in)
      else $error("read error without pop on empty");
   a_full_push_err: assert property (full_out && push_en_in && push_we_in |-> write_error_out)
      else $error("push on full not flagged");
   a_wr_err_keep: assert property (write_error_out |=> $stable(write_pointer_out))
      else $error("refused push moved pointer");
   a_rd_err_keep: assert property (read_error_out |=> $stable(read_pointer_out))
      else $error("refused pop moved pointer");
   a_wr_ptr_idle: assert property (!(push_en_in && push_we_in) |=> $stable(write_pointer_out))
      else $error("write pointer moved without push");
   a_empty_rd_hold: assert property (empty_out |=> $stable(read_pointer_out))
      else $error("read pointer moved while empty");
   c_overflow: cover property (write_error_out);
   c_underflow: cover property (read_error_out);
   c_leave_full: cover property (full_out ##1 !full_out);
endmodule : ram_fifo_chk

bind block_ram_fifo_controller ram_fifo_chk chk (.*);
